// ### hw/i2dr_pkg.sv
package i2dr_pkg;
    // Bus timing: one quarter of a standard-mode bit
    localparam int CORE_PERIOD_NS = 100;
    localparam int QTR_BIT_NS     = 2500;
    localparam int QTR_CYC        =
        (QTR_BIT_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int TICK_W         = 8;

    // Transfer shape
    localparam logic [3:0] XFER_LAST_BIT = 4'h8;
    localparam logic [3:0] RECOV_MAX     = 4'h9;

    // Host command codes
    localparam logic [7:0] CMD_START = 8'h53;
    localparam logic [7:0] CMD_STOP  = 8'h50;
    localparam logic [7:0] CMD_WRITE = 8'h57;
    localparam logic [7:0] CMD_READ  = 8'h52;
    localparam logic [7:0] CMD_PINS  = 8'h51;
    localparam logic [7:0] CMD_VER   = 8'h3f;

    // Greeting and revision text; values are arbitrary
    localparam int          GREET_LEN = 10;
    localparam logic [79:0] GREET_TXT = "I2C BRIDGE";
    localparam int          VER_LEN   = 2;
    localparam logic [15:0] VER_TXT   = "01";

    // Bus engine states, Gray along idle-start-bit-stop-recover
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_START = 3'h1,
        ST_BIT   = 3'h3,
        ST_STOP  = 3'h2,
        ST_RECOV = 3'h6
    } i2dr_state_type;

    // Reply sources
    typedef enum logic [1:0] {
        EM_NONE  = 2'h0,
        EM_GREET = 2'h1,
        EM_VER   = 2'h3,
        EM_BYTE  = 2'h2
    } i2dr_emit_type;
endpackage

// ### hw/i2dr_sync2.sv
`timescale 1ns/1ns
// Two-stage synchroniser; only the second stage is visible
module i2dr_sync2 #(
    parameter int W = 1
) (
    // Clocking
    input  wire logic         clk,
    input  wire logic         rst,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;

    // Capture chain
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule

// ### hw/i2dr_top.sv
`timescale 1ns/1ns
// Summary of operation
// - After failed stop, up to 9 extra clocks
// - Last read byte is not acknowledged by default
// - Override input acknowledges last read byte too
// - Pin-read command returns present line levels
// - Greeting string sent before commands accepted
// - Version query answered with two characters
module i2dr_top (
    // Core clock domain
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       core_ce,
    // Host link clock domain
    input  wire logic       host_clk,
    // Host commands
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire logic [7:0] cmd_code,
    input  wire logic [7:0] cmd_data,
    // Host replies
    output logic            rsp_valid,
    input  wire logic       rsp_ready,
    output logic      [7:0] rsp_data,
    // Control and status
    input  wire logic       ack_all,
    output logic            bus_stuck,
    // Open-drain bus pins
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe
);
    // Host domain registers
    logic       hcmd_tog_ff, hrsp_ack_ff;
    logic [7:0] hcmd_code_ff, hcmd_data_ff;
    logic       nxt_hcmd_tog, nxt_hrsp_ack;
    logic [7:0] nxt_hcmd_code, nxt_hcmd_data;
    logic       h_cmd_ack_s, h_rsp_tog_s;

    // Core domain registers
    i2dr_pkg::i2dr_state_type st_ff, nxt_st;
    i2dr_pkg::i2dr_emit_type  em_sel_ff, nxt_em_sel;
    logic [1:0]  q_ff, nxt_q;
    logic [i2dr_pkg::TICK_W-1:0] tick_ff, nxt_tick;
    logic [3:0]  bitcnt_ff, nxt_bitcnt, rec_ff, nxt_rec;
    logic [3:0]  em_idx_ff, nxt_em_idx;
    logic [8:0]  sh_ff, nxt_sh, rx_ff, nxt_rx;
    logic [7:0]  em_byte_ff, nxt_em_byte, rsp_byte_ff, nxt_rsp_byte;
    logic        rd_ff, nxt_rd, scl_lo_ff, nxt_scl_lo;
    logic        sda_lo_ff, nxt_sda_lo, stuck_ff, nxt_stuck;
    logic        rsp_tog_ff, nxt_rsp_tog, cmd_ack_ff, nxt_cmd_ack;
    logic        c_cmd_tog_s, c_rsp_ack_s, scl_s, sda_s;

    // Character of a reply string
    function automatic logic [7:0] str_char(
        input i2dr_pkg::i2dr_emit_type sel,
        input logic [3:0]              idx,
        input logic [7:0]              byt
    );
        logic [7:0] c;
        c = byt;
        if (sel == i2dr_pkg::EM_GREET)
            c = i2dr_pkg::GREET_TXT[8*(i2dr_pkg::GREET_LEN-1-int'(idx)) +: 8];
        else if (sel == i2dr_pkg::EM_VER)
            c = i2dr_pkg::VER_TXT[8*(i2dr_pkg::VER_LEN-1-int'(idx)) +: 8];
        return c;
    endfunction

    // Last index of a reply string
    function automatic logic [3:0] str_last(
        input i2dr_pkg::i2dr_emit_type sel
    );
        logic [3:0] n;
        n = 4'h0;
        if (sel == i2dr_pkg::EM_GREET)
            n = 4'(i2dr_pkg::GREET_LEN - 1);
        else if (sel == i2dr_pkg::EM_VER)
            n = 4'(i2dr_pkg::VER_LEN - 1);
        return n;
    endfunction

    // Crossings into each domain
    i2dr_sync2 #(.W(2)) u_sync_host (
        .clk (host_clk),
        .rst (sys_rst),
        .d   ({cmd_ack_ff, rsp_tog_ff}),
        .q   ({h_cmd_ack_s, h_rsp_tog_s})
    );
    i2dr_sync2 #(.W(4)) u_sync_core (
        .clk (core_clk),
        .rst (sys_rst),
        .d   ({hcmd_tog_ff, hrsp_ack_ff, scl_in, sda_in}),
        .q   ({c_cmd_tog_s, c_rsp_ack_s, scl_s, sda_s})
    );

    // Host side handshakes; words stay still while a toggle is open
    assign cmd_ready = (hcmd_tog_ff == h_cmd_ack_s);
    assign rsp_valid = (h_rsp_tog_s != hrsp_ack_ff);
    assign rsp_data  = rsp_byte_ff;

    // Host side next values
    always_comb begin
        nxt_hcmd_tog  = hcmd_tog_ff;
        nxt_hcmd_code = hcmd_code_ff;
        nxt_hcmd_data = hcmd_data_ff;
        nxt_hrsp_ack  = hrsp_ack_ff;
        if (cmd_valid && cmd_ready) begin
            nxt_hcmd_tog  = ~hcmd_tog_ff;
            nxt_hcmd_code = cmd_code;
            nxt_hcmd_data = cmd_data;
        end
        if (rsp_valid && rsp_ready)
            nxt_hrsp_ack = ~hrsp_ack_ff;
    end

    // Host side registers
    always_ff @(posedge host_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hcmd_tog_ff  <= 1'b0;
            hcmd_code_ff <= 8'h00;
            hcmd_data_ff <= 8'h00;
            hrsp_ack_ff  <= 1'b0;
        end else begin
            hcmd_tog_ff  <= nxt_hcmd_tog;
            hcmd_code_ff <= nxt_hcmd_code;
            hcmd_data_ff <= nxt_hcmd_data;
            hrsp_ack_ff  <= nxt_hrsp_ack;
        end
    end

    // Core next values: command dispatch, bus engine, reply emitter
    always_comb begin
        logic tick_done;
        tick_done    = 1'b0;
        nxt_st       = st_ff;
        nxt_q        = q_ff;
        nxt_tick     = tick_ff;
        nxt_bitcnt   = bitcnt_ff;
        nxt_rec      = rec_ff;
        nxt_sh       = sh_ff;
        nxt_rx       = rx_ff;
        nxt_rd       = rd_ff;
        nxt_scl_lo   = scl_lo_ff;
        nxt_sda_lo   = sda_lo_ff;
        nxt_stuck    = stuck_ff;
        nxt_em_sel   = em_sel_ff;
        nxt_em_idx   = em_idx_ff;
        nxt_em_byte  = em_byte_ff;
        nxt_rsp_byte = rsp_byte_ff;
        nxt_rsp_tog  = rsp_tog_ff;
        nxt_cmd_ack  = cmd_ack_ff;

        // Reply emitter, one character per handshake
        // greeting first
        if (em_sel_ff != i2dr_pkg::EM_NONE && rsp_tog_ff == c_rsp_ack_s) begin
            nxt_rsp_byte = str_char(em_sel_ff, em_idx_ff, em_byte_ff);
            nxt_rsp_tog  = ~rsp_tog_ff;
            nxt_em_idx   = em_idx_ff + 4'h1;
            if (em_idx_ff == str_last(em_sel_ff)) begin
                nxt_em_sel = i2dr_pkg::EM_NONE;
                nxt_em_idx = 4'h0;
            end
        end

        // Quarter-bit timer
        if (st_ff != i2dr_pkg::ST_IDLE) begin
            nxt_tick = tick_ff + 1'b1;
            if (tick_ff == i2dr_pkg::TICK_W'(i2dr_pkg::QTR_CYC - 1)) begin
                nxt_tick  = '0;
                tick_done = 1'b1;
                nxt_q     = q_ff + 2'h1;
            end
        end

        case (st_ff)
            i2dr_pkg::ST_IDLE: begin
                // Commands wait for greeting and any reply
                if (c_cmd_tog_s != cmd_ack_ff &&
                    em_sel_ff == i2dr_pkg::EM_NONE) begin
                    nxt_cmd_ack = ~cmd_ack_ff;
                    nxt_q       = 2'h0;
                    nxt_tick    = '0;
                    nxt_bitcnt  = 4'h0;
                    case (hcmd_code_ff)
                        i2dr_pkg::CMD_START: nxt_st = i2dr_pkg::ST_START;
                        i2dr_pkg::CMD_STOP: begin
                            nxt_st    = i2dr_pkg::ST_STOP;
                            nxt_stuck = 1'b0;
                        end
                        i2dr_pkg::CMD_WRITE: begin
                            nxt_st = i2dr_pkg::ST_BIT;
                            nxt_rd = 1'b0;
                            nxt_sh = {hcmd_data_ff, 1'b1};
                        end
                        i2dr_pkg::CMD_READ: begin
                            nxt_st = i2dr_pkg::ST_BIT;
                            nxt_rd = 1'b1;
                            nxt_sh = {8'hff, hcmd_data_ff[0] & ~ack_all};
                        end
                        i2dr_pkg::CMD_PINS: begin
                            nxt_em_sel  = i2dr_pkg::EM_BYTE;
                            nxt_em_byte = {6'h00, scl_s, sda_s};
                        end
                        i2dr_pkg::CMD_VER: nxt_em_sel = i2dr_pkg::EM_VER;
                        default: ;
                    endcase
                end
            end
            i2dr_pkg::ST_START: begin
                // Release, raise clock, pull data, pull clock
                if (tick_done) begin
                    case (q_ff)
                        2'h0: nxt_sda_lo = 1'b0;
                        2'h1: nxt_scl_lo = 1'b0;
                        2'h2: nxt_sda_lo = 1'b1;
                        default: begin
                            nxt_scl_lo = 1'b1;
                            nxt_st     = i2dr_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
            i2dr_pkg::ST_BIT: begin
                if (tick_done) begin
                    case (q_ff)
                        2'h0: nxt_sda_lo = ~sh_ff[8];
                        2'h1: nxt_scl_lo = 1'b0;
                        2'h2: nxt_rx = {rx_ff[7:0], sda_s};
                        default: begin
                            nxt_scl_lo = 1'b1;
                            nxt_sh     = {sh_ff[7:0], 1'b1};
                            nxt_bitcnt = bitcnt_ff + 4'h1;
                            if (bitcnt_ff == i2dr_pkg::XFER_LAST_BIT) begin
                                nxt_st     = i2dr_pkg::ST_IDLE;
                                nxt_sda_lo = 1'b0;
                                if (rd_ff) begin
                                    nxt_em_sel  = i2dr_pkg::EM_BYTE;
                                    nxt_em_byte = rx_ff[8:1];
                                end
                            end
                        end
                    endcase
                end
            end
            i2dr_pkg::ST_STOP: begin
                if (tick_done) begin
                    case (q_ff)
                        2'h0: nxt_sda_lo = 1'b1;
                        2'h1: nxt_scl_lo = 1'b0;
                        2'h2: nxt_sda_lo = 1'b0;
                        default: begin
                            nxt_st = i2dr_pkg::ST_IDLE;
                            if (!sda_s) begin
                                nxt_st  = i2dr_pkg::ST_RECOV;
                                nxt_rec = 4'h0;
                            end
                        end
                    endcase
                end
            end
            i2dr_pkg::ST_RECOV: begin
                if (tick_done) begin
                    case (q_ff)
                        2'h0: nxt_scl_lo = 1'b1;
                        2'h1: nxt_scl_lo = 1'b1;
                        2'h2: nxt_scl_lo = 1'b0;
                        default: begin
                            nxt_scl_lo = 1'b1;
                            nxt_rec    = rec_ff + 4'h1;
                            if (sda_s) begin
                                nxt_st = i2dr_pkg::ST_STOP;
                            end else if (rec_ff + 4'h1 ==
                                         i2dr_pkg::RECOV_MAX) begin
                                nxt_st     = i2dr_pkg::ST_IDLE;
                                nxt_stuck  = 1'b1;
                                nxt_scl_lo = 1'b0;
                            end
                        end
                    endcase
                end
            end
            default: nxt_st = i2dr_pkg::ST_IDLE;
        endcase
    end

    // Core registers, frozen while the clock enable is low
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff       <= i2dr_pkg::ST_IDLE;
            q_ff        <= 2'h0;
            tick_ff     <= '0;
            bitcnt_ff   <= 4'h0;
            rec_ff      <= 4'h0;
            sh_ff       <= 9'h1ff;
            rx_ff       <= 9'h000;
            rd_ff       <= 1'b0;
            scl_lo_ff   <= 1'b0;
            sda_lo_ff   <= 1'b0;
            stuck_ff    <= 1'b0;
            em_sel_ff   <= i2dr_pkg::EM_GREET;
            em_idx_ff   <= 4'h0;
            em_byte_ff  <= 8'h00;
            rsp_byte_ff <= 8'h00;
            rsp_tog_ff  <= 1'b0;
            cmd_ack_ff  <= 1'b0;
        end else if (core_ce) begin
            st_ff       <= nxt_st;
            q_ff        <= nxt_q;
            tick_ff     <= nxt_tick;
            bitcnt_ff   <= nxt_bitcnt;
            rec_ff      <= nxt_rec;
            sh_ff       <= nxt_sh;
            rx_ff       <= nxt_rx;
            rd_ff       <= nxt_rd;
            scl_lo_ff   <= nxt_scl_lo;
            sda_lo_ff   <= nxt_sda_lo;
            stuck_ff    <= nxt_stuck;
            em_sel_ff   <= nxt_em_sel;
            em_idx_ff   <= nxt_em_idx;
            em_byte_ff  <= nxt_em_byte;
            rsp_byte_ff <= nxt_rsp_byte;
            rsp_tog_ff  <= nxt_rsp_tog;
            cmd_ack_ff  <= nxt_cmd_ack;
        end
    end

    // Open-drain pins: drive low only
    assign scl_out   = 1'b0;
    assign sda_out   = 1'b0;
    assign scl_oe    = scl_lo_ff;
    assign sda_oe    = sda_lo_ff;
    assign bus_stuck = stuck_ff;
endmodule

// ### tb/i2dr_monitor.sv
`timescale 1ns/1ns
// Port-level watch of the bridge
module i2dr_monitor (
    // Clocks and reset
    input wire logic       core_clk,
    input wire logic       host_clk,
    input wire logic       sys_rst,
    // Host side
    input wire logic       cmd_valid,
    input wire logic       cmd_ready,
    input wire logic       rsp_valid,
    input wire logic       rsp_ready,
    input wire logic [7:0] rsp_data,
    // Bus side
    input wire logic       bus_stuck,
    input wire logic       scl_out,
    input wire logic       scl_oe,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       sda_in
);
    // Clock phases last at least part of a quarter bit
    sequence seq_scl_held_low;
        scl_oe [*8];
    endsequence
    sequence seq_scl_held_high;
        !scl_oe [*8];
    endsequence
    // Host handshakes
    a_cmd_taken: assert property (
        @(posedge host_clk) disable iff (sys_rst)
        cmd_valid && cmd_ready |=> !cmd_ready) else $error("slot not closed");
    a_rsp_hold: assert property (
        @(posedge host_clk) disable iff (sys_rst)
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
        else $error("reply changed before taken");
    a_rsp_taken: assert property (
        @(posedge host_clk) disable iff (sys_rst)
        rsp_valid && rsp_ready |=> !rsp_valid) else $error("reply not dropped");
    // Bus pins only pull low, with whole clock phases
    a_pins_open: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        !scl_out && !sda_out) else $error("pin driven high");
    a_scl_low: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        $rose(scl_oe) |-> seq_scl_held_low) else $error("clock low too short");
    a_scl_high: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        $fell(scl_oe) |-> seq_scl_held_high) else $error("clock high too short");
    // Giving up only with data still low, then lines released
    a_stuck_sda: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        $rose(bus_stuck) |-> !sda_in) else $error("stuck flag with data high");
    a_stuck_idle: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        $rose(bus_stuck) |-> ##[0:60] !scl_oe && !sda_oe)
        else $error("lines held after giving up");
endmodule

bind i2dr_top i2dr_monitor mon (
    .core_clk(core_clk), .host_clk(host_clk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp_data(rsp_data), .bus_stuck(bus_stuck),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
    .sda_oe(sda_oe), .sda_in(sda_in)
);

// ### tb/i2dr_slave.sv
`timescale 1ns/1ns
// Behavioural bus slave answering reads with one byte
module i2dr_slave (
    // Bus wires
    input  wire logic       scl,
    input  wire logic       sda,
    // Fault and data controls
    input  wire logic       jam,
    input  wire logic [7:0] rd_byte,
    // Pull-down and last acknowledge seen
    output logic            sda_low,
    output logic            acked,
    // Last byte clocked in from the bus
    output logic      [7:0] seen
);
    int         bitn   = 0;
    logic       active = 1'b0;
    logic       drv    = 1'b0;
    logic [7:0] sh     = 8'h00;
    // Commanded stuck-low fault overrides normal drive
    assign sda_low = jam | drv;
    // Start arms the slave, stop releases it
    always @(negedge sda) begin
        if (scl) begin
            active = 1'b1;
            bitn = -1;
            acked = 1'b0;
        end
    end
    always @(posedge sda) begin
        if (scl) begin
            active = 1'b0;
            drv = 1'b0;
        end
    end
    // Data bits and master acknowledge taken on rising edges
    always @(posedge scl) begin
        if (active && bitn == 8) begin
            acked = ~sda;
        end
        if (active && bitn >= 0 && bitn < 8) begin
            seen = {seen[6:0], sda};
        end
    end
    // next bit driven after an acknowledge
    always @(negedge scl) begin
        if (active && bitn == 8 && !acked) begin
            active = 1'b0;
        end else if (active) begin
            bitn = (bitn == 8) ? 0 : bitn + 1;
        end
        if (bitn == 0) begin
            sh = rd_byte;
        end
        drv = active && bitn < 8 && !sh[7 - bitn];
    end
endmodule

// ### tb/test_i2c_stop_deadlock_recovery.sv
`timescale 1ns/1ns
// Bench for the stop-recovery bridge with a behavioural slave
module test_i2c_stop_deadlock_recovery;
    logic        core_clk, host_clk, cmd_ready, rsp_valid, bus_stuck;
    logic        scl_out, scl_oe, sda_out, sda_oe, slv_low, slv_acked;
    logic        scl_w, sda_w;
    logic [7:0]  rsp_data, slv_seen;
    logic        sys_rst   = 1'b1;
    logic        core_ce   = 1'b1;
    logic        cmd_valid = 1'b0;
    logic        rsp_ready = 1'b0;
    logic        ack_all   = 1'b0;
    logic        jam       = 1'b0;
    logic [7:0]  cmd_code  = 8'h00;
    logic [7:0]  cmd_data  = 8'h00;
    logic [7:0]  rd_byte   = 8'h00;
    logic [31:0] rnd       = 32'hfad6dacc;
    logic [7:0]  exp_q[$];
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          falls = 0;
    // Open-drain wires with pull-ups
    assign scl_w = scl_oe ? scl_out : 1'b1;
    assign sda_w = (sda_oe ? sda_out : 1'b1) & ~slv_low;
    i2dr_top dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .core_ce(core_ce),
        .host_clk(host_clk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_code(cmd_code), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
        .rsp_ready(rsp_ready), .rsp_data(rsp_data), .ack_all(ack_all),
        .bus_stuck(bus_stuck), .scl_in(scl_w), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe)
    );
    i2dr_slave slv (
        .scl(scl_w), .sda(sda_w), .jam(jam), .rd_byte(rd_byte),
        .sda_low(slv_low), .acked(slv_acked), .seen(slv_seen)
    );
    // Clocks: core 100 ns, host link 15 ns with an odd phase
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        host_clk = 1'b0;
        forever begin
            #7 host_clk = 1'b1;
            #8 host_clk = 1'b0;
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Offer one command and hold it until the slot takes it
    task automatic cmd(input logic [7:0] code, input logic [7:0] data);
        int n;
        n = 0;
        @(posedge host_clk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        cmd_data <= data;
        do begin
            @(posedge host_clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 200000);
        cmd_valid <= 1'b0;
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 200000) begin
            @(posedge host_clk);
            n++;
        end
    endtask
    // Host takes replies at random, each against the oldest note
    always @(posedge host_clk) begin
        if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
            check(rsp_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
        end
        rnd = xs(rnd);
        rsp_ready <= rnd[1:0] != 2'h0;
    end
    // Core enable stalls and the hang guard
    always @(posedge core_clk) begin
        rnd = xs(rnd);
        core_ce <= rnd[2:0] != 3'h0;
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            results();
        end
    end
    always @(negedge scl_w) falls++;
    // Main sequence
    initial begin
        logic [7:0] b;
        for (int i = 9; i >= 0; i--) begin
            exp_q.push_back(i2dr_pkg::GREET_TXT[i*8 +: 8]);
        end
        exp_q.push_back(i2dr_pkg::VER_TXT[15:8]);
        exp_q.push_back(i2dr_pkg::VER_TXT[7:0]);
        repeat (6) @(posedge core_clk);
        check(8'({cmd_ready, rsp_valid, bus_stuck, scl_oe, sda_oe}), 8'h10);
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        cmd(i2dr_pkg::CMD_VER, 8'h00);
        // Last read: no acknowledge by default, acknowledged on override
        for (int m = 0; m < 2; m++) begin
            b = {1'b0, rnd[5:0], 1'b1};
            ack_all <= m[0];
            rd_byte <= b;
            exp_q.push_back(b);
            exp_q.push_back(b);
            exp_q.push_back(8'h03);
            cmd(i2dr_pkg::CMD_START, 8'h00);
            cmd(i2dr_pkg::CMD_READ, 8'h00);
            cmd(i2dr_pkg::CMD_READ, 8'h01);
            cmd(i2dr_pkg::CMD_STOP, 8'h00);
            cmd(i2dr_pkg::CMD_PINS, 8'h00);
            falls = 0;
            drain();
            check(8'(slv_acked), 8'(m));
            check(8'(falls > 0), 8'(m));
            check(8'(bus_stuck), 8'h00);
        end
        // Write: every data bit reaches the slave, stop then succeeds
        b = rnd[15:8];
        rd_byte <= 8'hff;
        exp_q.push_back(8'h03);
        cmd(i2dr_pkg::CMD_START, 8'h00);
        cmd(i2dr_pkg::CMD_WRITE, b);
        cmd(i2dr_pkg::CMD_STOP, 8'h00);
        cmd(i2dr_pkg::CMD_PINS, 8'h00);
        drain();
        check(slv_seen, b);
        check(8'(bus_stuck), 8'h00);
        // Data line jammed: nine pulses, then give up until next stop
        b = {rnd[7:1], 1'b1};
        ack_all <= 1'b0;
        rd_byte <= b;
        exp_q.push_back(b);
        cmd(i2dr_pkg::CMD_START, 8'h00);
        cmd(i2dr_pkg::CMD_READ, 8'h01);
        drain();
        jam <= 1'b1;
        falls = 0;
        exp_q.push_back(8'h02);
        cmd(i2dr_pkg::CMD_STOP, 8'h00);
        cmd(i2dr_pkg::CMD_PINS, 8'h00);
        drain();
        check(8'(falls), 8'h09);
        check(8'(bus_stuck), 8'h01);
        jam <= 1'b0;
        exp_q.push_back(8'h03);
        cmd(i2dr_pkg::CMD_STOP, 8'h00);
        cmd(i2dr_pkg::CMD_PINS, 8'h00);
        drain();
        check(8'(bus_stuck), 8'h00);
        check(8'(exp_q.size()), 8'h00);
        results();
    end
endmodule
